// ### rtl/evd_pkg.sv
// Purpose: shared constants and types for the exception vector dispatch block
// Assumes: one core clock, asynchronous active-high reset
// Notes:   vector numbers, classes and event bit indices live here
package evd_pkg;

    typedef enum logic [1:0] {
        EVD_FAULT     = 2'h0,
        EVD_TRAP      = 2'h1,
        EVD_ABORT     = 2'h2,
        EVD_INTERRUPT = 2'h3
    } evd_class_t;

    localparam int         EVD_VEC_W      = 8;
    localparam int         EVD_TBL_W      = 32;
    localparam int         EVD_GATE_BYTES = 8;
    localparam logic [7:0] EVD_VEC_DIV    = 8'h00;
    localparam logic [7:0] EVD_VEC_NMI    = 8'h02;
    localparam logic [7:0] EVD_VEC_UNDEF  = 8'h06;
    localparam logic [7:0] EVD_VEC_NOMATH = 8'h07;
    localparam logic [7:0] EVD_VEC_DBL    = 8'h08;
    localparam logic [7:0] EVD_VEC_TASK   = 8'h0A;
    localparam logic [7:0] EVD_VEC_ABSENT = 8'h0B;
    localparam logic [7:0] EVD_VEC_SS     = 8'h0C;
    localparam logic [7:0] EVD_VEC_PROT   = 8'h0D;
    localparam logic [7:0] EVD_VEC_PAGE   = 8'h0E;
    localparam logic [7:0] EVD_VEC_MATH   = 8'h10;
    localparam logic [7:0] EVD_VEC_ALIGN  = 8'h11;
    localparam logic [7:0] EVD_VEC_MCHK   = 8'h12;
    localparam logic [7:0] EVD_VEC_USER   = 8'h20;
    localparam logic [7:0] EVD_VEC_RST    = 8'h00;
    localparam logic [31:0] EVD_TBL_RST   = 32'h0000_0000;

    // event bits, lowest index wins when several are raised at once
    localparam int EVD_EV_DBL    = 0;
    localparam int EVD_EV_MCHK   = 1;
    localparam int EVD_EV_DIV    = 2;
    localparam int EVD_EV_UNDEF  = 3;
    localparam int EVD_EV_NOMATH = 4;
    localparam int EVD_EV_TASK   = 5;
    localparam int EVD_EV_ABSENT = 6;
    localparam int EVD_EV_SS     = 7;
    localparam int EVD_EV_PROT   = 8;
    localparam int EVD_EV_PAGE   = 9;
    localparam int EVD_EV_MATH   = 10;
    localparam int EVD_EV_ALIGN  = 11;
    localparam int EVD_EV_NUM = 12;

endpackage : evd_pkg

// ### rtl/evd_classify.sv
// Purpose: turn a one-hot-ish exception request word into vector, class and code flag
// Assumes: purely combinational, registered by the caller
// Notes:   lowest set bit wins; no priority semantics beyond that
`timescale 1ns/100ps
module evd_classify
    import evd_pkg::*;
(
    input  wire logic [EVD_EV_NUM-1:0] excReq,
    output logic                       excAny,
    output logic [EVD_VEC_W-1:0]       excVec,
    output evd_class_t                 excClass,
    output logic                       excHasCode
);

    // fixed vector for each event bit
    function automatic logic [EVD_VEC_W-1:0] evVector(input int idx);
        case (idx)
            EVD_EV_DBL:    evVector = EVD_VEC_DBL;
            EVD_EV_MCHK:   evVector = EVD_VEC_MCHK;
            EVD_EV_DIV:    evVector = EVD_VEC_DIV;
            EVD_EV_UNDEF:  evVector = EVD_VEC_UNDEF;
            EVD_EV_NOMATH: evVector = EVD_VEC_NOMATH;
            EVD_EV_TASK:   evVector = EVD_VEC_TASK;
            EVD_EV_ABSENT: evVector = EVD_VEC_ABSENT;
            EVD_EV_SS:     evVector = EVD_VEC_SS;
            EVD_EV_PROT:   evVector = EVD_VEC_PROT;
            EVD_EV_PAGE:   evVector = EVD_VEC_PAGE;
            EVD_EV_MATH:   evVector = EVD_VEC_MATH;
            EVD_EV_ALIGN:  evVector = EVD_VEC_ALIGN;
            default:       evVector = EVD_VEC_RST;
        endcase
    endfunction : evVector

    // double fault and machine check abort, everything else here is a fault
    function automatic evd_class_t evClass(input int idx);
        case (idx)
            EVD_EV_DBL, EVD_EV_MCHK: evClass = EVD_ABORT;
            default:              evClass = EVD_FAULT;
        endcase
    endfunction : evClass

    // machine check is given no code here; the code is implementation-defined
    function automatic logic evCode(input int idx);
        case (idx)
            EVD_EV_DBL, EVD_EV_TASK, EVD_EV_ABSENT, EVD_EV_SS,
            EVD_EV_PROT, EVD_EV_PAGE, EVD_EV_ALIGN: evCode = 1'b1;
            default:                          evCode = 1'b0;
        endcase
    endfunction : evCode

    // walk from the top so the lowest index is written last and wins
    always_comb begin
        excAny     = 1'b0;
        excVec     = EVD_VEC_RST;
        excClass   = EVD_FAULT;
        excHasCode = 1'b0;
        for (int i = EVD_EV_NUM - 1; i >= 0; i--) begin
            if (excReq[i]) begin
                excAny     = 1'b1;
                excVec     = evVector(i);
                excClass   = evClass(i);
                excHasCode = evCode(i);
            end
        end
    end

endmodule : evd_classify

// ### rtl/evd_dispatch.sv
// Purpose: pick the next exception or interrupt and hand its vector to dispatch
// Assumes: requests are levels from the core, synchronous to clk
// Notes:   one event in service at a time; handler return reopens acceptance
`timescale 1ns/100ps
module evd_dispatch
    import evd_pkg::*;
#(
    parameter int TBL_W = EVD_TBL_W
)(
    input  wire logic                  clk,
    input  wire logic                  rst,
    // local pins and controller state
    input  wire logic [1:0]            localInterruptPins,
    input  wire logic                  localCtrlEnable,
    input  wire logic [EVD_VEC_W-1:0]  localVecTable0,
    input  wire logic [EVD_VEC_W-1:0]  localVecTable1,
    input  wire logic                  flagsIntMask,
    // vector read from the system bus controller
    output logic                       busAckReq,
    input  wire logic                  busVecValid,
    input  wire logic [EVD_VEC_W-1:0]  busVec,
    // core-side exception and software requests
    input  wire logic [EVD_EV_NUM-1:0] excReq,
    input  wire logic                  swIntReq,
    input  wire logic [EVD_VEC_W-1:0]  swIntVec,
    input  wire logic                  instrRetired,
    input  wire logic [TBL_W-1:0]      curInstrAddr,
    input  wire logic [TBL_W-1:0]      nextInstrAddr,
    input  wire logic [TBL_W-1:0]      tableBase,
    input  wire logic                  handlerDone,
    // dispatch outputs
    output logic                       dispValid,
    output logic [EVD_VEC_W-1:0]       dispVec,
    output evd_class_t                 dispClass,
    output logic                       dispHasCode,
    output logic [TBL_W-1:0]           dispEntryAddr,
    output logic [TBL_W-1:0]           dispReturnAddr,
    output logic                       dispRestoreState,
    output logic                       coreSuspend,
    output logic                       badVecReject
);

    typedef enum logic [1:0] {
        EVD_IDLE    = 2'b00,
        EVD_FETCH   = 2'b01,
        EVD_HANDLER = 2'b11
    } evd_state_t;

    evd_state_t                 state_reg;
    logic                       nmiPrev_reg;
    logic                       pin0Prev_reg;
    logic                       pin1Prev_reg;
    logic                       excAny;
    logic [EVD_VEC_W-1:0]       excVec;
    evd_class_t                 excClass;
    logic                       excHasCode;
    logic                       maskPin;
    logic                       nmiPin;
    logic                       nmiEdge;
    logic                       tblHit;
    logic [EVD_VEC_W-1:0]       tblVec;
    logic                       takeEvent;
    logic [EVD_VEC_W-1:0]       selVec;
    evd_class_t                 selClass;
    logic                       selHasCode;
    logic [TBL_W-1:0]           selRet;
    logic                       selRestore;

    // reserved range check used for both pin-table and bus vectors
    function automatic logic isArchVec(input logic [EVD_VEC_W-1:0] v);
        isArchVec = (v < EVD_VEC_USER);
    endfunction : isArchVec

    evd_classify u_classify (
        .excReq     (excReq),
        .excAny     (excAny),
        .excVec     (excVec),
        .excClass   (excClass),
        .excHasCode (excHasCode)
    );

    // pin roles follow the local controller enable
    assign maskPin = !localCtrlEnable && localInterruptPins[0];
    assign nmiPin  = !localCtrlEnable && localInterruptPins[1];
    assign nmiEdge = nmiPin && !nmiPrev_reg;

    // enabled controller: a rising pin raises its programmed vector; masked like maskable
    always_comb begin
        tblHit = 1'b0;
        tblVec = localVecTable0;
        if (localCtrlEnable && !flagsIntMask) begin
            if (localInterruptPins[0] && !pin0Prev_reg) begin
                tblHit = 1'b1;
                tblVec = localVecTable0;
            end else if (localInterruptPins[1] && !pin1Prev_reg) begin
                tblHit = 1'b1;
                tblVec = localVecTable1;
            end
        end
    end

    // selection when idle: exceptions, nonmaskable, software, local table
    always_comb begin
        takeEvent  = 1'b1;
        selVec     = excVec;
        selClass   = excClass;
        selHasCode = excHasCode;
        selRet     = curInstrAddr;
        selRestore = 1'b1;
        if (excAny) begin
            selRet     = curInstrAddr;
            selRestore = (excClass == EVD_FAULT);
        end else if (nmiEdge) begin
            selVec     = EVD_VEC_NMI;
            selClass   = EVD_INTERRUPT;
            selHasCode = 1'b0;
            selRet     = nextInstrAddr;
            selRestore = 1'b0;
        end else if (swIntReq && instrRetired) begin
            selVec     = swIntVec;
            selClass   = EVD_TRAP;
            selHasCode = 1'b0;
            selRet     = nextInstrAddr;
            selRestore = 1'b0;
        end else if (tblHit && !isArchVec(tblVec)) begin
            selVec     = tblVec;
            selClass   = EVD_INTERRUPT;
            selHasCode = 1'b0;
            selRet     = nextInstrAddr;
            selRestore = 1'b0;
        end else begin
            takeEvent  = 1'b0;
        end
    end

    // pin history for edge detection
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            nmiPrev_reg  <= 1'b0;
            pin0Prev_reg <= 1'b0;
            pin1Prev_reg <= 1'b0;
        end else begin
            nmiPrev_reg  <= nmiPin;
            pin0Prev_reg <= localInterruptPins[0];
            pin1Prev_reg <= localInterruptPins[1];
        end
    end

    // sequencing: accept, optionally fetch a bus vector, run handler, resume
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= EVD_IDLE;
        end else begin
            case (state_reg)
                EVD_IDLE: begin
                    if (takeEvent) begin
                        state_reg <= EVD_HANDLER;
                    end else if (maskPin && !flagsIntMask) begin
                        state_reg <= EVD_FETCH;
                    end
                end
                EVD_FETCH: begin
                    if (excAny) begin
                        state_reg <= EVD_HANDLER;
                    end else if (busVecValid) begin
                        state_reg <= isArchVec(busVec) ? EVD_IDLE : EVD_HANDLER;
                    end
                end
                EVD_HANDLER: begin
                    if (handlerDone) begin
                        state_reg <= EVD_IDLE;
                    end
                end
                default: state_reg <= EVD_IDLE;
            endcase
        end
    end

    // dispatch record, one-cycle valid pulse with held fields
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dispValid        <= 1'b0;
            dispVec          <= EVD_VEC_RST;
            dispClass        <= EVD_FAULT;
            dispHasCode      <= 1'b0;
            dispEntryAddr    <= EVD_TBL_RST;
            dispReturnAddr   <= EVD_TBL_RST;
            dispRestoreState <= 1'b0;
            badVecReject     <= 1'b0;
        end else begin
            dispValid    <= 1'b0;
            badVecReject <= 1'b0;
            if (state_reg == EVD_IDLE && takeEvent) begin
                dispValid        <= 1'b1;
                dispVec          <= selVec;
                dispClass        <= selClass;
                dispHasCode      <= selHasCode;
                dispEntryAddr    <= tableBase + TBL_W'(selVec) * TBL_W'(EVD_GATE_BYTES);
                dispReturnAddr   <= selRet;
                dispRestoreState <= selRestore;
            end else if (state_reg == EVD_FETCH && excAny) begin
                dispValid        <= 1'b1;
                dispVec          <= EVD_VEC_DBL;
                dispClass        <= EVD_ABORT;
                dispHasCode      <= 1'b1;
                dispEntryAddr    <= tableBase + TBL_W'(EVD_VEC_DBL) * TBL_W'(EVD_GATE_BYTES);
                dispReturnAddr   <= curInstrAddr;
                dispRestoreState <= 1'b0;
            end else if (state_reg == EVD_FETCH && busVecValid) begin
                if (isArchVec(busVec)) begin
                    badVecReject <= 1'b1;
                end else begin
                    dispValid        <= 1'b1;
                    dispVec          <= busVec;
                    dispClass        <= EVD_INTERRUPT;
                    dispHasCode      <= 1'b0;
                    dispEntryAddr    <= tableBase + TBL_W'(busVec) * TBL_W'(EVD_GATE_BYTES);
                    dispReturnAddr   <= nextInstrAddr;
                    dispRestoreState <= 1'b0;
                end
            end
        end
    end

    // bus acknowledge and core suspend are registered from the state and the pending requests
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busAckReq   <= 1'b0;
            coreSuspend <= 1'b0;
        end else begin
            busAckReq   <= (state_reg == EVD_IDLE && !takeEvent && maskPin && !flagsIntMask)
                        || (state_reg == EVD_FETCH && !busVecValid && !excAny);
            coreSuspend <= (state_reg == EVD_IDLE && (takeEvent || (maskPin && !flagsIntMask)))
                        || (state_reg == EVD_FETCH && !(busVecValid && isArchVec(busVec)))
                        || (state_reg == EVD_HANDLER && !handlerDone);
        end
    end

    // nonmaskable edge seen while idle with no exception yields vector 2 with no error code next cycle
    sequence SEQ_NMI_SEEN;
        state_reg == EVD_IDLE && !excAny && nmiEdge;
    endsequence
    sequence SEQ_NMI_OUT;
        dispValid && dispVec == EVD_VEC_NMI && dispClass == EVD_INTERRUPT && !dispHasCode;
    endsequence
    AST_NMI_VECTOR: assert property (@(posedge clk) disable iff (rst)
        SEQ_NMI_SEEN |=> SEQ_NMI_OUT) else $error("nmi not dispatched on vector 2");

    AST_DBL_DURING_FETCH: assert property (@(posedge clk) disable iff (rst)
        (state_reg == EVD_FETCH && excAny) |=> (dispValid && dispVec == EVD_VEC_DBL
            && dispClass == EVD_ABORT && dispHasCode && state_reg == EVD_HANDLER))
        else $error("exception during delivery not a double fault");

    AST_MASK_BLOCKS: assert property (@(posedge clk) disable iff (rst)
        (state_reg == EVD_IDLE && flagsIntMask && !takeEvent) |=> state_reg != EVD_FETCH)
        else $error("masked request started a vector fetch");

    AST_NO_ARCH_FROM_BUS: assert property (@(posedge clk) disable iff (rst)
        (state_reg == EVD_FETCH && busVecValid && !excAny && isArchVec(busVec))
            |=> (badVecReject && !dispValid && state_reg == EVD_IDLE))
        else $error("reserved bus vector accepted");

    AST_BUS_VECTOR: assert property (@(posedge clk) disable iff (rst)
        (state_reg == EVD_FETCH && busVecValid && !excAny && !isArchVec(busVec))
            |=> (dispValid && dispVec == $past(busVec) && dispClass == EVD_INTERRUPT))
        else $error("bus vector not dispatched");

    AST_ENTRY_INDEX: assert property (@(posedge clk) disable iff (rst)
        dispValid |-> dispEntryAddr == $past(tableBase) + TBL_W'(dispVec) * TBL_W'(EVD_GATE_BYTES))
        else $error("entry address not indexed by vector");

    AST_FAULT_RETURN: assert property (@(posedge clk) disable iff (rst)
        (dispValid && dispClass == EVD_FAULT) |-> (dispRestoreState && dispReturnAddr == $past(curInstrAddr)))
        else $error("fault return address wrong");

    AST_TRAP_RETURN: assert property (@(posedge clk) disable iff (rst)
        (dispValid && dispClass == EVD_TRAP) |-> (dispReturnAddr == $past(nextInstrAddr) && !dispRestoreState))
        else $error("trap return address wrong");

    AST_HANDLER_HOLD: assert property (@(posedge clk) disable iff (rst)
        (state_reg == EVD_HANDLER && !handlerDone) |=> (coreSuspend && state_reg == EVD_HANDLER))
        else $error("core resumed before handler done");

    AST_DIVIDE_VEC: assert property (@(posedge clk) disable iff (rst)
        (state_reg == EVD_IDLE && excReq == EVD_EV_NUM'(1 << EVD_EV_DIV))
            |=> (dispValid && dispVec == EVD_VEC_DIV && dispClass == EVD_FAULT && !dispHasCode))
        else $error("divide error mis-dispatched");

    AST_PAGE_VEC: assert property (@(posedge clk) disable iff (rst)
        (state_reg == EVD_IDLE && excReq == EVD_EV_NUM'(1 << EVD_EV_PAGE))
            |=> (dispValid && dispVec == EVD_VEC_PAGE && dispHasCode))
        else $error("page fault mis-dispatched");

    AST_UNDEF_VEC: assert property (@(posedge clk) disable iff (rst)
        (state_reg == EVD_IDLE && excReq == EVD_EV_NUM'(1 << EVD_EV_UNDEF))
            |=> (dispValid && dispVec == EVD_VEC_UNDEF && dispClass == EVD_FAULT && !dispHasCode))
        else $error("undefined opcode mis-dispatched");

    AST_NOMATH_VEC: assert property (@(posedge clk) disable iff (rst)
        (state_reg == EVD_IDLE && excReq == EVD_EV_NUM'(1 << EVD_EV_NOMATH))
            |=> (dispValid && dispVec == EVD_VEC_NOMATH && dispClass == EVD_FAULT && !dispHasCode))
        else $error("math unit unavailable mis-dispatched");

    AST_TASK_VEC: assert property (@(posedge clk) disable iff (rst)
        (state_reg == EVD_IDLE && excReq == EVD_EV_NUM'(1 << EVD_EV_TASK))
            |=> (dispValid && dispVec == EVD_VEC_TASK && dispClass == EVD_FAULT && dispHasCode))
        else $error("bad task state mis-dispatched");

    AST_MATH_VEC: assert property (@(posedge clk) disable iff (rst)
        (state_reg == EVD_IDLE && excReq == EVD_EV_NUM'(1 << EVD_EV_MATH))
            |=> (dispValid && dispVec == EVD_VEC_MATH && dispClass == EVD_FAULT && !dispHasCode))
        else $error("math fault mis-dispatched");

    AST_ALIGN_VEC: assert property (@(posedge clk) disable iff (rst)
        (state_reg == EVD_IDLE && excReq == EVD_EV_NUM'(1 << EVD_EV_ALIGN))
            |=> (dispValid && dispVec == EVD_VEC_ALIGN && dispClass == EVD_FAULT && dispHasCode))
        else $error("alignment check mis-dispatched");

    AST_MCHK_VEC: assert property (@(posedge clk) disable iff (rst)
        (state_reg == EVD_IDLE && excReq == EVD_EV_NUM'(1 << EVD_EV_MCHK))
            |=> (dispValid && dispVec == EVD_VEC_MCHK && dispClass == EVD_ABORT))
        else $error("machine check mis-dispatched");

    // software request wins over table pins but yields to exceptions and nonmaskable
    AST_SW_VEC: assert property (@(posedge clk) disable iff (rst)
        (state_reg == EVD_IDLE && !excAny && !nmiEdge && swIntReq && instrRetired)
            |=> (dispValid && dispVec == $past(swIntVec) && dispClass == EVD_TRAP && !dispHasCode))
        else $error("software interrupt mis-dispatched");

    AST_TABLE_VEC: assert property (@(posedge clk) disable iff (rst)
        (state_reg == EVD_IDLE && !excAny && !nmiEdge && !(swIntReq && instrRetired) && tblHit
            && !isArchVec(tblVec)) |=> (dispValid && dispVec == $past(tblVec) && dispClass == EVD_INTERRUPT))
        else $error("table pin vector not dispatched");

    // a reserved table vector is dropped without any dispatch
    AST_TABLE_RESERVED: assert property (@(posedge clk) disable iff (rst)
        (state_reg == EVD_IDLE && !excAny && !nmiEdge && !(swIntReq && instrRetired) && tblHit
            && isArchVec(tblVec)) |=> !dispValid)
        else $error("reserved table vector dispatched");

    AST_FETCH_START: assert property (@(posedge clk) disable iff (rst)
        (state_reg == EVD_IDLE && !takeEvent && maskPin && !flagsIntMask)
            |=> (busAckReq && state_reg == EVD_FETCH))
        else $error("maskable request did not start a vector fetch");

    AST_ONE_PULSE: assert property (@(posedge clk) disable iff (rst)
        dispValid |=> !dispValid)
        else $error("dispatch valid held for more than one cycle");

endmodule : evd_dispatch

// ### dv/evd_vec_source.sv
// Purpose: vector source on the system bus side of the dispatcher
// Assumes: one answer per request, after a chosen number of cycles
// Notes:   vector lines toggle while not valid so stale data cannot pass for a vector
`timescale 1ns/100ps
module evd_vec_source
    import evd_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic                 busAckReq,
    input  wire logic [EVD_VEC_W-1:0] vecIn,
    input  wire logic [3:0]           delay,
    output logic                      busVecValid,
    output logic [EVD_VEC_W-1:0]      busVec
);
    logic [3:0] waitCnt_reg;

    // single pulse per request; the cycle after it is skipped so a held request is not answered twice
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            waitCnt_reg <= 4'h0;
            busVecValid <= 1'b0;
            busVec      <= 8'h5A;
        end else begin
            busVecValid <= 1'b0;
            busVec      <= ~busVec;
            if (busAckReq && !busVecValid && waitCnt_reg == delay) begin
                busVecValid <= 1'b1;
                busVec      <= vecIn;
                waitCnt_reg <= 4'h0;
            end else if (busAckReq && !busVecValid) begin
                waitCnt_reg <= waitCnt_reg + 4'h1;
            end else begin
                waitCnt_reg <= 4'h0;
            end
        end
    end
endmodule : evd_vec_source

// ### dv/exception_vector_dispatch_test.sv
// Purpose: self-checking bench for the exception vector dispatcher
// Assumes: inputs change on the falling edge, outputs looked at 1 ns after the rising edge, or on the falling edge around reset and after handler return
// Notes:   exception table as rows; interrupts and odd cases written by hand
`timescale 1ns/100ps
module exception_vector_dispatch_test
    import evd_pkg::*;
;
    typedef struct {int b; logic [7:0] v; evd_class_t c; logic e;} evd_row_t;
    logic        clk = 0, rst = 1, ctrlEn = 0, intMask = 0, swIntReq = 0, retired = 0, handlerDone = 0;
    logic        busAckReq, busVecValid, dispValid, dispHasCode, dispRestoreState, coreSuspend, badVecReject;
    logic [1:0]  pins = 2'h0;
    logic [3:0]  pDelay = 4'h0;
    logic [7:0]  tbl0 = 8'h50, tbl1 = 8'h08, pVec = 8'h40, swVec = 8'h23, busVec, dispVec;
    logic [11:0] excReq = 12'h000;
    logic [31:0] curA = 32'h0000_1000, nextA = 32'h0000_1004, base = 32'h0002_0000, entryA, retA;
    evd_class_t  dispClass;
    int          errors = 0, checked = 0;
    evd_row_t    rows [12] = '{
        '{EVD_EV_DIV, 8'h00, EVD_FAULT, 1'b0}, '{EVD_EV_UNDEF, 8'h06, EVD_FAULT, 1'b0},
        '{EVD_EV_NOMATH, 8'h07, EVD_FAULT, 1'b0}, '{EVD_EV_DBL, 8'h08, EVD_ABORT, 1'b1},
        '{EVD_EV_TASK, 8'h0A, EVD_FAULT, 1'b1}, '{EVD_EV_ABSENT, 8'h0B, EVD_FAULT, 1'b1},
        '{EVD_EV_SS, 8'h0C, EVD_FAULT, 1'b1}, '{EVD_EV_PROT, 8'h0D, EVD_FAULT, 1'b1},
        '{EVD_EV_PAGE, 8'h0E, EVD_FAULT, 1'b1}, '{EVD_EV_MATH, 8'h10, EVD_FAULT, 1'b0},
        '{EVD_EV_ALIGN, 8'h11, EVD_FAULT, 1'b1}, '{EVD_EV_MCHK, 8'h12, EVD_ABORT, 1'b0}};

    // 125 MHz core clock
    always #4 clk = ~clk;

    evd_dispatch i_evd_dispatch (.clk(clk), .rst(rst), .localInterruptPins(pins), .localCtrlEnable(ctrlEn),
        .localVecTable0(tbl0), .localVecTable1(tbl1), .flagsIntMask(intMask), .busAckReq(busAckReq),
        .busVecValid(busVecValid), .busVec(busVec), .excReq(excReq), .swIntReq(swIntReq), .swIntVec(swVec),
        .instrRetired(retired), .curInstrAddr(curA), .nextInstrAddr(nextA), .tableBase(base),
        .handlerDone(handlerDone), .dispValid(dispValid), .dispVec(dispVec), .dispClass(dispClass),
        .dispHasCode(dispHasCode), .dispEntryAddr(entryA), .dispReturnAddr(retA),
        .dispRestoreState(dispRestoreState), .coreSuspend(coreSuspend), .badVecReject(badVecReject));

    evd_vec_source i_evd_vec_source (.clk(clk), .rst(rst), .busAckReq(busAckReq), .vecIn(pVec),
        .delay(pDelay), .busVecValid(busVecValid), .busVec(busVec));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // bounded wait on a settled output, never on a fixed count
    task automatic wait_for(ref logic s, input logic lvl, input int n);
        for (int i = 0; i < n && s !== lvl; i++) begin
            @(posedge clk);
            #1;
        end
    endtask : wait_for

    task automatic expect_disp(input logic [7:0] v, input evd_class_t c, input logic e, r, input logic [31:0] ra);
        wait_for(dispValid, 1'b1, 20);
        chk(dispValid, 1);
        chk(dispVec, v);
        chk(dispClass, c);
        chk(dispHasCode, e);
        chk(entryA, base + {21'h0, v, 3'h0});
        chk(retA, ra);
        chk(dispRestoreState, r);
        chk(coreSuspend, 1);
    endtask : expect_disp

    // drop every request and return from the handler on the same falling edge
    task automatic done_evt(input string name);
        @(negedge clk);
        excReq = 12'h000;
        pins = 2'h0;
        swIntReq = 0;
        handlerDone = 1;
        @(negedge clk);
        handlerDone = 0;
        wait_for(coreSuspend, 1'b0, 10);
        chk(coreSuspend, 0);
        $display("test %s done", name);
        @(negedge clk);
    endtask : done_evt

    task automatic tally_and_finish;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish

    // the whole run needs well under a thousand cycles
    initial begin
        #20000;
        errors++;
        tally_and_finish();
    end

    initial begin
        repeat (8) @(negedge clk);
        chk(coreSuspend, 0);
        rst = 0;
        foreach (rows[i]) begin
            @(negedge clk);
            excReq[rows[i].b] = 1'b1;
            expect_disp(rows[i].v, rows[i].c, rows[i].e, rows[i].c == EVD_FAULT, curA);
            done_evt("exception row");
        end
        pins = 2'b10;
        expect_disp(8'h02, EVD_INTERRUPT, 0, 0, nextA);
        done_evt("nonmaskable");
        pins = 2'b01;
        wait_for(busAckReq, 1'b1, 5);
        chk(busAckReq, 1);
        expect_disp(8'h40, EVD_INTERRUPT, 0, 0, nextA);
        done_evt("bus vector");
        pVec = 8'h05;
        pins = 2'b01;
        wait_for(badVecReject, 1'b1, 20);
        chk(badVecReject, 1);
        chk(dispValid, 0);
        @(negedge clk);
        pins = 2'b00;
        wait_for(coreSuspend, 1'b0, 20);
        $display("test reserved bus vector done");
        @(negedge clk);
        pVec = 8'h40;
        intMask = 1;
        pins = 2'b01;
        repeat (6) @(posedge clk);
        #1;
        chk(busAckReq, 0);
        @(negedge clk);
        pins = 2'b11;
        expect_disp(8'h02, EVD_INTERRUPT, 0, 0, nextA);
        done_evt("masked");
        intMask = 0;
        pDelay = 4'hA;
        pins = 2'b01;
        wait_for(busAckReq, 1'b1, 5);
        @(negedge clk);
        excReq[EVD_EV_UNDEF] = 1'b1;
        expect_disp(8'h08, EVD_ABORT, 1, 0, curA);
        done_evt("double fault in fetch");
        pDelay = 4'h0;
        swIntReq = 1;
        retired = 1;
        expect_disp(8'h23, EVD_TRAP, 0, 0, nextA);
        done_evt("software");
        retired = 0;
        ctrlEn = 1;
        pins = 2'b10;
        repeat (5) @(posedge clk);
        #1;
        chk(coreSuspend, 0);
        @(negedge clk);
        pins = 2'b11;
        expect_disp(8'h50, EVD_INTERRUPT, 0, 0, nextA);
        done_evt("local table");
        ctrlEn = 0;
        rst = 1;
        @(negedge clk);
        chk(busAckReq, 0);
        chk(dispValid, 0);
        rst = 0;
        $display("test mid reset done");
        tally_and_finish();
    end
endmodule : exception_vector_dispatch_test
